// ---- macrocell_sum_term_logic.v ----
`timescale 1ns/100ps
`include "macrocell_defines.vh"

module macrocell_sum_term_logic (
    // system
    input wire clk_in,
    input wire rst_in,
    // buses and pins
    input wire [`MC_GBUS_W-1:0] global_bus_in,
    input wire [`MC_REG_SIGS-1:0] regional_bus_in,
    input wire cascade_input_in,
    input wire [3:0] dedicated_pins_in,
    input wire [2:0] global_clock_pins_in,
    // array configuration
    input wire [`MC_SW_SIGS*`MC_GBUS_IDX_W-1:0] switch_sel_cfg_in,
    input wire [`MC_NUM_PT*`MC_PT_IN-1:0] pt_true_mask_in,
    input wire [`MC_NUM_PT*`MC_PT_IN-1:0] pt_comp_mask_in,
    input wire [`MC_NUM_PT*3-1:0] pt_route_cfg_in,
    input wire [2:0] foldback_sel_in,
    input wire cascade_use_in,
    // macrocell configuration
    input wire [1:0] xor_sel_cfg_in,
    input wire [1:0] ff_mode_cfg_in,
    input wire [1:0] clock_src_cfg_in,
    input wire clock_enable_use_in,
    input wire [1:0] reset_mode_cfg_in,
    input wire [1:0] reset_pin_sel_in,
    input wire [1:0] oe_mode_cfg_in,
    input wire [1:0] oe_pin_sel_in,
    input wire out_registered_in,
    input wire feedback_registered_in,
    // protection
    input wire security_fuse_in,
    input wire [`MC_SIG_W-1:0] user_signature_in,
    // test access port
    input wire tck_in,
    input wire tms_in,
    input wire tdi_in,
    output reg tdo_out,
    output wire tdo_oe_out,
    // macrocell outputs
    output reg macro_out,
    output reg macro_oe_out,
    output reg buried_feedback_out,
    output reg foldback_out,
    output wire cascade_out
);

    // test port states
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PA_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UP_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SH_IR = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PA_IR = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UP_IR = 4'hF;

    wire [`MC_SW_SIGS-1:0] switch_sigs;
    wire [`MC_PT_IN-1:0] term_inputs;
    wire [`MC_NUM_PT-1:0] terms;
    reg [`MC_NUM_PT-1:0] term_enable;
    reg [`MC_NUM_PT-1:0] sum_terms;
    reg xor_pt;
    reg clk_pt;
    reg rst_pt;
    reg set_pt;
    reg ce_pt;
    reg oe_pt;
    reg [2:0] route;
    integer k;
    wire sum_term;
    reg xor_b;
    reg xor_out;
    wire comb_out;
    reg cell_clock;
    reg cell_clear;
    wire q;
    reg next_oe;
    reg [3:0] tap_state;
    reg [3:0] next_tap_state;
    reg [1:0] ir_shift;
    reg [1:0] ir;
    reg [`MC_DR_W-1:0] dr_shift;
    reg [`MC_DR_W-1:0] config_word;
    reg tck_prev;
    wire tck_rise;
    wire tck_fall;

    genvar s;
    generate
        for (s = 0; s < `MC_SW_SIGS; s = s + 1) begin : g_switch
            wire [`MC_GBUS_IDX_W-1:0] idx;
            assign idx = switch_sel_cfg_in[s*`MC_GBUS_IDX_W +: `MC_GBUS_IDX_W];
            // an index past the bus picks nothing, so it reads low
            assign switch_sigs[s] = (idx < `MC_GBUS_W) ? global_bus_in[idx] : 1'h0;
        end
    endgenerate

    assign term_inputs = {regional_bus_in, switch_sigs};

    product_term_array u_terms (
        .term_in(term_inputs),
        .true_mask_in(pt_true_mask_in),
        .comp_mask_in(pt_comp_mask_in),
        .term_enable_in(term_enable),
        .term_out(terms)
    );

    always @* begin
        term_enable = {`MC_NUM_PT{1'h0}};
        sum_terms = {`MC_NUM_PT{1'h0}};
        xor_pt = 1'h0;
        clk_pt = 1'h0;
        rst_pt = 1'h0;
        set_pt = 1'h0;
        ce_pt = 1'h0;
        oe_pt = 1'h0;
        route = `PT_ROUTE_OFF;
        for (k = 0; k < `MC_NUM_PT; k = k + 1) begin
            route = pt_route_cfg_in[k*3 +: 3];
            term_enable[k] = (route != `PT_ROUTE_OFF);
            case (route)
                `PT_ROUTE_SUM: sum_terms[k] = terms[k];
                `PT_ROUTE_XOR: xor_pt = xor_pt | terms[k];
                `PT_ROUTE_CLK: clk_pt = clk_pt | terms[k];
                `PT_ROUTE_RST: rst_pt = rst_pt | terms[k];
                `PT_ROUTE_SET: set_pt = set_pt | terms[k];
                `PT_ROUTE_CE: ce_pt = ce_pt | terms[k];
                `PT_ROUTE_OE: oe_pt = oe_pt | terms[k];
                default: term_enable[k] = 1'h0;
            endcase
        end
    end

    assign sum_term = (|sum_terms) | (cascade_use_in & cascade_input_in);
    // passed on unregistered so a chain of MC_CASCADE_MAX (40) cells settles in one cycle
    assign cascade_out = sum_term;

    always @* begin
        case (xor_sel_cfg_in)
            `XOR_SEL_PT: xor_b = xor_pt;
            `XOR_SEL_LOW: xor_b = 1'h0;
            `XOR_SEL_HIGH: xor_b = 1'h1;
            default: xor_b = 1'h0;
        endcase
    end

    assign comb_out = sum_term ^ xor_b;

    always @* begin
        case (ff_mode_cfg_in)
            `FF_MODE_T: xor_out = sum_term ^ q;
            `FF_MODE_JK: xor_out = (sum_term & ~q) | (~xor_pt & q);
            default: xor_out = comb_out;
        endcase
    end

    always @* begin
        case (clock_src_cfg_in)
            2'h0: cell_clock = global_clock_pins_in[0];
            2'h1: cell_clock = global_clock_pins_in[1];
            2'h2: cell_clock = global_clock_pins_in[2];
            default: cell_clock = clk_pt;
        endcase
        case (reset_mode_cfg_in)
            `RST_MODE_PIN: cell_clear = dedicated_pins_in[reset_pin_sel_in];
            `RST_MODE_PT: cell_clear = rst_pt;
            `RST_MODE_BOTH: cell_clear = dedicated_pins_in[reset_pin_sel_in] | rst_pt;
            default: cell_clear = 1'h0;
        endcase
    end

    // enable only with a global clock
    storage_element u_store (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .latch_mode_in(ff_mode_cfg_in == `FF_MODE_LATCH),
        .cell_clock_in(cell_clock),
        .ce_use_in(clock_enable_use_in && (clock_src_cfg_in != `CLK_SRC_PT)),
        .ce_in(ce_pt),
        .clear_in(cell_clear),
        .preset_in(set_pt),
        .d_in(xor_out),
        .q_out(q)
    );

    always @* begin
        case (oe_mode_cfg_in)
            `OE_MODE_ON: next_oe = 1'h1;
            `OE_MODE_OFF: next_oe = 1'h0;
            `OE_MODE_PIN: next_oe = dedicated_pins_in[oe_pin_sel_in];
            default: next_oe = oe_pt;
        endcase
    end

    // output flops; registered and combinatorial paths both see one stage here
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            macro_out <= 1'h0;
            macro_oe_out <= 1'h0;
            buried_feedback_out <= 1'h0;
            foldback_out <= 1'h0;
        end else begin
            macro_out <= out_registered_in ? q : comb_out;
            macro_oe_out <= next_oe;
            buried_feedback_out <= feedback_registered_in ? q : comb_out;
            foldback_out <= (foldback_sel_in < `MC_NUM_PT) ? ~terms[foldback_sel_in] : 1'h0;
        end
    end

    always @* begin
        config_word = {`MC_DR_W{1'h0}};
        if (!security_fuse_in) begin
            config_word = {3'h0, pt_route_cfg_in, xor_sel_cfg_in, ff_mode_cfg_in,
                clock_src_cfg_in, reset_mode_cfg_in, oe_mode_cfg_in, out_registered_in,
                feedback_registered_in, cascade_use_in, clock_enable_use_in};
        end
    end

    assign tck_rise = tck_in & ~tck_prev;
    assign tck_fall = ~tck_in & tck_prev;
    assign tdo_oe_out = (tap_state == ST_SH_DR) || (tap_state == ST_SH_IR);

    always @* begin
        case (tap_state)
            ST_RESET: next_tap_state = tms_in ? ST_RESET : ST_IDLE;
            ST_IDLE: next_tap_state = tms_in ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_tap_state = tms_in ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_tap_state = tms_in ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_tap_state = tms_in ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_tap_state = tms_in ? ST_UP_DR : ST_PA_DR;
            ST_PA_DR: next_tap_state = tms_in ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_tap_state = tms_in ? ST_UP_DR : ST_SH_DR;
            ST_UP_DR: next_tap_state = tms_in ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_tap_state = tms_in ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_tap_state = tms_in ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_tap_state = tms_in ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_tap_state = tms_in ? ST_UP_IR : ST_PA_IR;
            ST_PA_IR: next_tap_state = tms_in ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_tap_state = tms_in ? ST_UP_IR : ST_SH_IR;
            ST_UP_IR: next_tap_state = tms_in ? ST_SEL_DR : ST_IDLE;
            default: next_tap_state = ST_RESET;
        endcase
    end

    // tap registers move on the sampled rising edge of tck
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tck_prev <= 1'h0;
            tap_state <= ST_RESET;
            ir_shift <= `IR_BYPASS;
            ir <= `IR_BYPASS;
            dr_shift <= {`MC_DR_W{1'h0}};
            tdo_out <= 1'h0;
        end else begin
            tck_prev <= tck_in;
            if (tck_rise) begin
                tap_state <= next_tap_state;
                case (tap_state)
                    ST_RESET: ir <= `IR_BYPASS;
                    ST_CAP_IR: ir_shift <= `IR_CAPTURE;
                    ST_SH_IR: ir_shift <= {tdi_in, ir_shift[1]};
                    ST_UP_IR: ir <= ir_shift;
                    ST_CAP_DR: begin
                        case (ir)
                            `IR_CONFIG: dr_shift <= config_word;
                            `IR_SIGNATURE: dr_shift <= {16'h0000, user_signature_in};
                            default: dr_shift <= {`MC_DR_W{1'h0}};
                        endcase
                    end
                    ST_SH_DR: begin
                        // chain length follows the instruction
                        case (ir)
                            `IR_CONFIG: dr_shift <= {tdi_in, dr_shift[31:1]};
                            `IR_SIGNATURE: dr_shift <= {16'h0000, tdi_in, dr_shift[15:1]};
                            default: dr_shift <= {31'h00000000, tdi_in};
                        endcase
                    end
                    default: dr_shift <= dr_shift;
                endcase
            end
            // tdo changes on the falling edge so the far end samples it stable
            if (tck_fall) begin
                tdo_out <= (tap_state == ST_SH_IR) ? ir_shift[0] : dr_shift[0];
            end
        end
    end

endmodule

// ---- macrocell_defines.vh ----
`ifndef MACROCELL_DEFINES_VH
`define MACROCELL_DEFINES_VH

// array sizes
`define MC_NUM_PT 5
`define MC_SW_SIGS 40
`define MC_REG_SIGS 16
`define MC_PT_IN 56
`define MC_GBUS_W 136
`define MC_GBUS_IDX_W 8
`define MC_NUM_CELLS 64
`define MC_CASCADE_MAX 40
`define MC_SIG_W 16
`define MC_DR_W 32

// product term route codes, 3 bits per term
`define PT_ROUTE_SUM 3'h0
`define PT_ROUTE_XOR 3'h1
`define PT_ROUTE_CLK 3'h2
`define PT_ROUTE_RST 3'h3
`define PT_ROUTE_SET 3'h4
`define PT_ROUTE_CE 3'h5
`define PT_ROUTE_OE 3'h6
`define PT_ROUTE_OFF 3'h7

// second xor input
`define XOR_SEL_PT 2'h0
`define XOR_SEL_LOW 2'h1
`define XOR_SEL_HIGH 2'h2

// storage element modes
`define FF_MODE_D 2'h0
`define FF_MODE_T 2'h1
`define FF_MODE_JK 2'h2
`define FF_MODE_LATCH 2'h3

// clock source, codes 0 to 2 pick a global clock pin
`define CLK_SRC_PT 2'h3

// reset source
`define RST_MODE_OFF 2'h0
`define RST_MODE_PIN 2'h1
`define RST_MODE_PT 2'h2
`define RST_MODE_BOTH 2'h3

// output enable source
`define OE_MODE_ON 2'h0
`define OE_MODE_OFF 2'h1
`define OE_MODE_PIN 2'h2
`define OE_MODE_PT 2'h3

// test port instructions and reset values
`define IR_CONFIG 2'h0
`define IR_SIGNATURE 2'h1
`define IR_BYPASS 2'h3
`define IR_CAPTURE 2'h1
`define RST_Q 1'h0

`endif

// ---- product_term_array.v ----
`timescale 1ns/100ps
`include "macrocell_defines.vh"

module product_term_array (
    // term inputs
    input wire [`MC_PT_IN-1:0] term_in,
    // per-term masks, true and complement literal
    input wire [`MC_NUM_PT*`MC_PT_IN-1:0] true_mask_in,
    input wire [`MC_NUM_PT*`MC_PT_IN-1:0] comp_mask_in,
    input wire [`MC_NUM_PT-1:0] term_enable_in,
    // and terms
    output wire [`MC_NUM_PT-1:0] term_out
);

    genvar i;
    // one and gate per term; a disabled term reads low to save power downstream
    generate
        for (i = 0; i < `MC_NUM_PT; i = i + 1) begin : g_term
            wire [`MC_PT_IN-1:0] tm;
            wire [`MC_PT_IN-1:0] cm;
            assign tm = true_mask_in[i*`MC_PT_IN +: `MC_PT_IN];
            assign cm = comp_mask_in[i*`MC_PT_IN +: `MC_PT_IN];
            assign term_out[i] = term_enable_in[i] & (&(~tm | term_in)) & (&(~cm | ~term_in));
        end
    endgenerate

endmodule

// ---- storage_element.v ----
`timescale 1ns/100ps
`include "macrocell_defines.vh"

module storage_element (
    // system
    input wire clk_in,
    input wire rst_in,
    // control
    input wire latch_mode_in,
    input wire cell_clock_in,
    input wire ce_use_in,
    input wire ce_in,
    input wire clear_in,
    input wire preset_in,
    // data
    input wire d_in,
    output reg q_out
);

    reg clock_prev;
    wire clock_rise;

    // macro clock is sampled, so its edge is found against the last sample
    assign clock_rise = cell_clock_in & ~clock_prev;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clock_prev <= 1'h0;
        end else begin
            clock_prev <= cell_clock_in;
        end
    end

    // clear beats preset; both act regardless of the clock
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_out <= `RST_Q;
        end else if (clear_in) begin
            q_out <= 1'h0;
        end else if (preset_in) begin
            q_out <= 1'h1;
        end else if (latch_mode_in) begin
            if (cell_clock_in) begin
                q_out <= d_in;
            end
        end else if (clock_rise && (!ce_use_in || ce_in)) begin
            q_out <= d_in;
        end
    end

endmodule

// ---- macrocell_sum_term_logic_asserts.sv ----
`timescale 1ns/100ps
`include "macrocell_defines.vh"
module macrocell_checker (
    // system
    input wire clk_in,
    input wire rst_in,
    // watched inputs
    input wire [3:0] dedicated_pins_in,
    input wire cascade_input_in,
    input wire cascade_use_in,
    input wire [`MC_NUM_PT*3-1:0] pt_route_cfg_in,
    input wire [2:0] foldback_sel_in,
    input wire [1:0] xor_sel_cfg_in,
    input wire [1:0] oe_mode_cfg_in,
    input wire [1:0] oe_pin_sel_in,
    input wire out_registered_in,
    input wire feedback_registered_in,
    // watched outputs
    input wire macro_out,
    input wire macro_oe_out,
    input wire buried_feedback_out,
    input wire foldback_out,
    input wire cascade_out
);
    // all terms off, so the sum is the cascade alone
    wire idle = pt_route_cfg_in == 15'h7FFF;
    wire pass = idle && cascade_use_in && !out_registered_in;
    reg pin_oe;
    // pin value one edge back, matches the output stage
    always @(posedge clk_in) pin_oe <= dedicated_pins_in[oe_pin_sel_in];
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_oe_on; oe_mode_cfg_in == `OE_MODE_ON |=> macro_oe_out; endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe not on");
    property p_oe_pin; oe_mode_cfg_in == `OE_MODE_PIN |=> macro_oe_out == pin_oe; endproperty
    a_oe_pin: assert property (p_oe_pin) else $error("oe not from pin");
    property p_casc_pass; idle && cascade_use_in |-> cascade_out == cascade_input_in; endproperty
    a_casc_pass: assert property (p_casc_pass) else $error("cascade lost");
    property p_casc_off; idle && !cascade_use_in |-> !cascade_out; endproperty
    a_casc_off: assert property (p_casc_off) else $error("cascade leaks");
    property p_pol_inv;
        pass && xor_sel_cfg_in == `XOR_SEL_HIGH |=> macro_out == !$past(cascade_input_in);
    endproperty
    a_pol_inv: assert property (p_pol_inv) else $error("no inversion");
    property p_pol_keep;
        pass && xor_sel_cfg_in == `XOR_SEL_LOW |=> macro_out == $past(cascade_input_in);
    endproperty
    a_pol_keep: assert property (p_pol_keep) else $error("sum altered");
    property p_fb_comb;
        idle && cascade_use_in && !feedback_registered_in && xor_sel_cfg_in == `XOR_SEL_LOW
        |=> buried_feedback_out == $past(cascade_input_in);
    endproperty
    a_fb_comb: assert property (p_fb_comb) else $error("feedback wrong");
    property p_fold_off; foldback_sel_in > 3'h4 |=> !foldback_out; endproperty
    a_fold_off: assert property (p_fold_off) else $error("foldback not 0");
    property p_fold_inv;
        foldback_sel_in == 3'h0 && pt_route_cfg_in[2:0] == `PT_ROUTE_OFF |=> foldback_out;
    endproperty
    a_fold_inv: assert property (p_fold_inv) else $error("foldback not inverse");
    c_casc: cover property (cascade_use_in && cascade_out);
    c_oe: cover property ($rose(macro_oe_out));
    c_fold: cover property (foldback_sel_in == 3'h1 && !foldback_out);
endmodule
bind macrocell_sum_term_logic macrocell_checker u_chk (.clk_in, .rst_in, .dedicated_pins_in,
    .cascade_input_in, .cascade_use_in, .pt_route_cfg_in, .foldback_sel_in, .xor_sel_cfg_in,
    .oe_mode_cfg_in, .oe_pin_sel_in, .out_registered_in, .feedback_registered_in, .macro_out,
    .macro_oe_out, .buried_feedback_out, .foldback_out, .cascade_out);

// ---- macrocell_neighbours.sv ----
`timescale 1ns/100ps
`include "macrocell_defines.vh"
module macrocell_neighbours (
    // from the bench
    input wire [67:0] io_pins_in,
    input wire [3:0] ded_pins_in,
    input wire [62:0] other_fb_in,
    input wire [14:0] other_fold_in,
    input wire neigh_sum_in,
    // from the cell
    input wire own_fb_in,
    input wire own_fold_in,
    // to the cell
    output wire [`MC_GBUS_W-1:0] global_bus_out,
    output wire [`MC_REG_SIGS-1:0] regional_bus_out,
    output wire cascade_out
);
    assign global_bus_out = {ded_pins_in, io_pins_in, other_fb_in, own_fb_in};
    assign regional_bus_out = {own_fold_in, other_fold_in};
    assign cascade_out = neigh_sum_in;
endmodule

// ---- macrocell_sum_term_logic_bench.sv ----
`timescale 1ns/100ps
`include "macrocell_defines.vh"
module macrocell_sum_term_logic_bench;
    reg clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg [67:0] io;
    reg [3:0] ded;
    reg [14:0] ofold, route;
    reg [2:0] gclk, fsel;
    reg [319:0] sw;
    reg [279:0] tm, cm;
    reg [15:0] sig;
    reg [31:0] dr;
    reg nsum, cuse, ceuse, oreg, freg, fuse, tck, tms, tdi;
    reg [1:0] xsel, fmode, csrc, rmode, rpin, omode, opin;
    wire [135:0] gbus;
    wire [15:0] rbus;
    wire casc, tdo, tdo_oe, mout, moe, bfb, fold, cout;
    integer bad_count = 0;
    integer checks = 0;
    integer i, j;
    macrocell_neighbours nb (.io_pins_in(io), .ded_pins_in(ded), .other_fb_in(63'h0),
        .other_fold_in(ofold), .neigh_sum_in(nsum), .own_fb_in(bfb), .own_fold_in(fold),
        .global_bus_out(gbus), .regional_bus_out(rbus), .cascade_out(casc));
    macrocell_sum_term_logic DUT (.clk_in(clk_in), .rst_in(rst_in), .global_bus_in(gbus),
        .regional_bus_in(rbus), .cascade_input_in(casc), .dedicated_pins_in(ded),
        .global_clock_pins_in(gclk), .switch_sel_cfg_in(sw), .pt_true_mask_in(tm),
        .pt_comp_mask_in(cm), .pt_route_cfg_in(route), .foldback_sel_in(fsel),
        .cascade_use_in(cuse), .xor_sel_cfg_in(xsel), .ff_mode_cfg_in(fmode),
        .clock_src_cfg_in(csrc), .clock_enable_use_in(ceuse), .reset_mode_cfg_in(rmode),
        .reset_pin_sel_in(rpin), .oe_mode_cfg_in(omode), .oe_pin_sel_in(opin),
        .out_registered_in(oreg), .feedback_registered_in(freg), .security_fuse_in(fuse),
        .user_signature_in(sig), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
        .tdo_oe_out(tdo_oe), .macro_out(mout), .macro_oe_out(moe), .buried_feedback_out(bfb),
        .foldback_out(fold), .cascade_out(cout));
    // free-running system clock
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_in);
            #1;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // neutral setup: switch signal n reads io pin n, all terms off
    task cfg;
        begin
            for (i = 0; i < 40; i = i + 1) sw[i*8 +: 8] = 8'h40 + i[7:0];
            tm = 0;
            cm = 0;
            route = 15'h7FFF;
            {io, ded, ofold, gclk, fsel, nsum, cuse, ceuse, oreg, freg, fuse} = 0;
            {fmode, csrc, rmode, rpin, omode, opin, tck, tdi} = 0;
            xsel = `XOR_SEL_LOW;
            tms = 1'b1;
            sig = 16'hA5C3;
        end
    endtask
    task t_sum;
        begin
            cfg;
            route = 15'h0;
            for (i = 0; i < 5; i = i + 1) tm[i*56+i] = 1'b1;
            for (i = 0; i < 6; i = i + 1) begin
                io = (68'h1 << i) & 68'h1F;
                cyc(2);
                chk(mout, i < 5);
            end
            tm[4*56+4] = 1'b0;
            tm[4*56+40] = 1'b1;
            ofold = 15'h1;
            cyc(2);
            chk(mout, 1);
            $display("t_sum done");
        end
    endtask
    task t_xor;
        begin
            cfg;
            route = 15'h7FC8;
            tm[0] = 1'b1;
            tm[57] = 1'b1;
            for (j = 0; j < 3; j = j + 1) begin
                xsel = j[1:0];
                for (i = 0; i < 4; i = i + 1) begin
                    io = i;
                    cyc(2);
                    chk(mout, io[0] ^ (xsel == `XOR_SEL_PT ? io[1] : xsel == `XOR_SEL_HIGH));
                end
            end
            $display("t_xor done");
        end
    endtask
    task t_casc;
        begin
            cfg;
            cuse = 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                nsum = i[0];
                xsel = i > 1 ? `XOR_SEL_HIGH : `XOR_SEL_LOW;
                cyc(2);
                chk(cout, nsum);
                chk(mout, nsum ^ (i > 1));
            end
            cuse = 1'b0;
            cyc(1);
            chk(cout, 0);
            $display("t_casc done");
        end
    endtask
    task pulse;
        begin
            gclk[0] = 1'b1;
            cyc(2);
            gclk[0] = 1'b0;
            cyc(2);
        end
    endtask
    // term0 sum, term1 xor, term2 clock enable
    task t_ff;
        begin
            cfg;
            route = 15'h7F48;
            tm[0] = 1'b1;
            tm[57] = 1'b1;
            tm[114] = 1'b1;
            oreg = 1'b1;
            io = 1;
            pulse;
            chk(mout, 1);
            io = 0;
            cyc(4);
            chk(mout, 1);
            ceuse = 1'b1;
            pulse;
            chk(mout, 1);
            io = 4;
            pulse;
            chk(mout, 0);
            ceuse = 1'b0;
            fmode = `FF_MODE_T;
            io = 1;
            pulse;
            chk(mout, 1);
            {rmode, rpin, omode, opin, ded} = {`RST_MODE_PIN, 2'h2, `OE_MODE_PIN, 2'h2, 4'h4};
            cyc(3);
            chk(mout, 0);
            chk(moe, 1);
            ded = 4'h0;
            rmode = `RST_MODE_OFF;
            cyc(2);
            chk(moe, 0);
            pulse;
            chk(mout, 1);
            fmode = `FF_MODE_JK;
            for (i = 0; i < 4; i = i + 1) begin
                io = i < 2 ? i + 1 : 3;
                pulse;
                chk(mout, i % 2 == 0);
            end
            $display("t_ff done");
        end
    endtask
    task t_latch;
        begin
            cfg;
            route = 15'h7FF8;
            tm[0] = 1'b1;
            {oreg, fmode, gclk} = {1'b1, `FF_MODE_LATCH, 3'h1};
            for (i = 0; i < 3; i = i + 1) begin
                io = i % 2 == 0;
                gclk[0] = i < 2;
                cyc(4);
                chk(mout, i == 0);
            end
            $display("t_latch done");
        end
    endtask
    task t_fold;
        begin
            cfg;
            route = 15'h7FC7;
            tm[57] = 1'b1;
            fsel = 3'h1;
            for (i = 0; i < 2; i = i + 1) begin
                io = i * 2;
                cyc(2);
                chk(fold, i == 0);
                chk(bfb, i);
            end
            fsel = 3'h7;
            // term low, so only the out-of-range select can hold the foldback low
            io = 0;
            cyc(2);
            chk(fold, 0);
            $display("t_fold done");
        end
    endtask
    // tck low then high, tdo taken before the rise
    task step(input s, input d);
        begin
            tms = s;
            tdi = d;
            tck = 1'b0;
            cyc(3);
            dr = {tdo, dr[31:1]};
            tck = 1'b1;
            cyc(2);
        end
    endtask
    task scan(input [1:0] ir, input integer n);
        begin
            for (i = 0; i < 6; i = i + 1) step(i < 5, 0);
            for (i = 0; i < 4; i = i + 1) step(i < 2, 0);
            chk(tdo_oe, 1);
            step(0, ir[0]);
            step(1, ir[1]);
            chk(dr[31:30], `IR_CAPTURE);
            for (i = 0; i < 4; i = i + 1) step(i < 2, 0);
            for (i = 0; i < n; i = i + 1) step(i == n - 1, 0);
            chk(tdo_oe, 0);
        end
    endtask
    task t_tap;
        begin
            cfg;
            fuse = 1'b1;
            scan(`IR_SIGNATURE, 16);
            chk(dr[31:16], sig);
            scan(`IR_CONFIG, 32);
            chk(dr, 0);
            fuse = 1'b0;
            scan(`IR_CONFIG, 32);
            chk(dr[28:12], {route, xsel});
            $display("t_tap done");
        end
    endtask
    task final_report;
        begin
            $display("checks=%0d mismatches=%0d", checks, bad_count);
            if (bad_count == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // tests need about 760 cycles, allow far more
    initial begin
        #100000;
        bad_count = bad_count + 1;
        final_report;
    end
    initial begin
        cfg;
        cyc(8);
        rst_in = 1'b0;
        t_sum;
        t_xor;
        t_casc;
        t_ff;
        t_latch;
        t_fold;
        t_tap;
        final_report;
    end
endmodule
